// ===== hdl/iesl_consts.vh
// constants for the instrument error and setup logic
// Contract
// [RL1] cal-not-enabled or list-down gives -221, exec bit
// [RL2] out-of-range value gives -222, exec bit
// [RL3] list storage full gives -223, exec bit
// [RL4] dwell count mismatch gives -226, exec bit
// [RL5] power stage no response gives -240
// [RL6] check modes 1-3: window fault, output off
// [RL7] save/recall/cal-store failure gives -311, device bit
// [RL8] dropped errors give -350 queue overflow
// [RL9] output buffer 253 chars; loss gives -400
// [RL10] unread query reply gives -420 query error
// [RL11] over/undervoltage may set device error bit
// [RL12] factory init: filler, status-only clear, reset-off
// [RL13] status-only clear: only status registers cleared
// [RL14] clear-as-reset: 0V, off unless reset-on
// [RL15] filler option: empty-buffer read returns line feed
// [RL16] reset-off: reset/power-up give off, 0V, 0A
// [RL17] reset-on: reset gives output on, 0V, 0A
// [RL18] presets: standard all options 0; legacy all 1
// [RL19] settings query returns three labelled option digits
// [RL20] version query returns year.revision
// [RL21] protected command without password gives -231
// [RL22] diagnostic save stores options for power-on
// [RL23] fifo error queue keeps oldest; empty reads 0
// [RL24] error push and status bit in same step
`ifndef IESL_CONSTS_VH
`define IESL_CONSTS_VH
`define IESL_ERR_NONE 9'h000
`define IESL_ERR_CONFLICT 9'h1_23
`define IESL_ERR_RANGE 9'h1_22
`define IESL_ERR_TOO_MUCH 9'h1_21
`define IESL_ERR_LIST_LEN 9'h1_1e
`define IESL_ERR_PROTECTED 9'h1_19
`define IESL_ERR_HARDWARE 9'h1_10
`define IESL_ERR_VOLTAGE 9'h0_d3
`define IESL_ERR_CURRENT 9'h0_d2
`define IESL_ERR_MEMORY 9'h0_c9
`define IESL_ERR_OVERFLOW 9'h0_a2
`define IESL_ERR_QUERY 9'h0_70
`define IESL_ERR_UNTERM 9'h0_5c
`define IESL_ESR_QUERY 2
`define IESL_ESR_DEVICE 3
`define IESL_ESR_EXEC 4
`define IESL_QUEUE_DEPTH 16
`define IESL_QPTR_W 4
`define IESL_OUTBUF_LIMIT 8'h00_fd
`define IESL_LF_CHAR 8'h0a
`define IESL_VERSION_YEAR 16'h07_cd
`define IESL_VERSION_REV 4'h0
`define IESL_STAGE_TIMEOUT_US 100
`define IESL_CLK_MHZ 40
// stage timeout in clock cycles, sized to the watchdog counter
`define IESL_STAGE_TIMEOUT_CYC 13'h0f_a0
`endif

// ===== hdl/iesl_core.v
// error classification, error queue and behaviour-select options
`include "iesl_consts.vh"
module iesl_core (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // command-step event pulses, with the status levels and counts they are checked against
  input wire cal_cmd_p,
  input wire cal_enabled,
  input wire list_dir_down_p,
  input wire value_out_of_range_p,
  input wire list_full_p,
  input wire list_cmd_done_p,
  input wire [7:0] dwell_count,
  input wire [7:0] volt_count,
  input wire [7:0] curr_count,
  input wire stage_cmd_p,
  input wire stage_ack_p,
  input wire [1:0] output_check_mode,
  input wire volt_window_fault,
  input wire curr_window_fault,
  input wire memory_fail_p,
  input wire ov_uv_detect,
  input wire protected_cmd_p,
  input wire password_enabled,
  // response path
  input wire resp_byte_p,
  input wire query_sent_p,
  input wire host_read_p,
  // error query
  input wire err_read_p,
  input wire esr_clear_p,
  // option commands
  input wire set_status_only_p,
  input wire set_clear_reset_p,
  input wire set_no_filler_p,
  input wire set_filler_p,
  input wire set_reset_off_p,
  input wire set_reset_on_p,
  input wire preset_std_p,
  input wire preset_legacy_p,
  input wire factory_init_p,
  input wire diag_save_p,
  input wire reset_cmd_p,
  input wire device_clear_p,
  input wire output_on_cmd_p,
  input wire output_off_cmd_p,
  // saved options for power-on
  input wire [2:0] saved_opts,
  // outputs
  output reg [8:0] err_code_ff,
  output reg err_empty_ff,
  output reg [7:0] esr_ff,
  output reg output_on_ff,
  output reg setpoint_zero_ff,
  output reg status_clear_ff,
  output reg clear_as_reset_ff,
  output reg filler_lf_ff,
  output reg reset_out_on_ff,
  output reg [7:0] read_byte_ff,
  output reg read_valid_ff,
  output reg [2:0] save_opts_ff,
  output reg save_strobe_ff,
  output reg [15:0] version_year_ff,
  output reg [3:0] version_rev_ff
);

////////////////////////////////////////////////////////////////////////////////
reg rst_s1_ff;
reg rst_s2_ff;
wire rst_n;
always @(posedge clk or negedge arst_n)
begin
  if (!arst_n)
  begin
    rst_s1_ff <= 1'b0;
    rst_s2_ff <= 1'b0;
  end
  else
  begin
    rst_s1_ff <= 1'b1;
    rst_s2_ff <= rst_s1_ff;
  end
end
assign rst_n = rst_s2_ff;

////////////////////////////////////////////////////////////////////////////////
// first clocked cycle after release loads saved options
reg boot_ff;
reg [7:0] outbuf_cnt_ff;
reg pending_query_ff;
reg [12:0] stage_cnt_ff;
reg stage_wait_ff;
wire list_len_bad;
wire stage_timeout;
wire window_fault;
wire [12:0] stage_limit;

assign stage_limit = `IESL_STAGE_TIMEOUT_CYC;
assign list_len_bad = list_cmd_done_p && (dwell_count != 8'h01) &&
  (dwell_count != volt_count) && (dwell_count != curr_count); // [RL4]
assign stage_timeout = stage_wait_ff && (stage_cnt_ff == stage_limit); // [RL5]
assign window_fault = (output_check_mode != 2'h0) &&
  (volt_window_fault || curr_window_fault); // [RL6]

// one error per step, highest priority first
function [8:0] iesl_pick;
  input [11:0] ev;
  begin
    casez (ev)
      12'b1???_????_????: iesl_pick = `IESL_ERR_PROTECTED;
      12'b01??_????_????: iesl_pick = `IESL_ERR_CONFLICT;
      12'b001?_????_????: iesl_pick = `IESL_ERR_RANGE;
      12'b0001_????_????: iesl_pick = `IESL_ERR_TOO_MUCH;
      12'b0000_1???_????: iesl_pick = `IESL_ERR_LIST_LEN;
      12'b0000_01??_????: iesl_pick = `IESL_ERR_HARDWARE;
      12'b0000_001?_????: iesl_pick = `IESL_ERR_VOLTAGE;
      12'b0000_0001_????: iesl_pick = `IESL_ERR_CURRENT;
      12'b0000_0000_1???: iesl_pick = `IESL_ERR_MEMORY;
      12'b0000_0000_01??: iesl_pick = `IESL_ERR_QUERY;
      12'b0000_0000_001?: iesl_pick = `IESL_ERR_UNTERM;
      default: iesl_pick = `IESL_ERR_NONE;
    endcase
  end
endfunction

wire [11:0] events;
wire volt_fault_ev;
wire curr_fault_ev;
wire query_lost;
assign volt_fault_ev = window_fault && volt_window_fault && output_on_ff;
assign curr_fault_ev = window_fault && curr_window_fault && !volt_window_fault && output_on_ff;
assign query_lost = resp_byte_p && (outbuf_cnt_ff == `IESL_OUTBUF_LIMIT); // [RL9]
assign events = {protected_cmd_p && !password_enabled, // [RL21]
  (cal_cmd_p && !cal_enabled) || list_dir_down_p, // [RL1]
  value_out_of_range_p, // [RL2]
  list_full_p, // [RL3]
  list_len_bad, stage_timeout, volt_fault_ev, curr_fault_ev,
  memory_fail_p, // [RL7]
  query_lost,
  query_sent_p && pending_query_ff, // [RL10]
  1'b0};
wire [8:0] new_code;
wire new_err;
assign new_code = iesl_pick(events);
assign new_err = (new_code != `IESL_ERR_NONE);

////////////////////////////////////////////////////////////////////////////////
// error fifo, last slot reserved for overflow marker
reg [8:0] queue_mem [0:`IESL_QUEUE_DEPTH-1];
reg [`IESL_QPTR_W-1:0] wr_ptr_ff;
reg [`IESL_QPTR_W-1:0] rd_ptr_ff;
reg [`IESL_QPTR_W:0] count_ff;
reg overflowed_ff;
wire q_full_data;
wire do_pop;
wire do_push;
wire push_ovf;
wire [8:0] push_code;
assign do_pop = err_read_p && (count_ff != 5'h00);
// nothing is queued behind the overflow marker until the queue drains
assign q_full_data = (count_ff >= 5'h0f) || overflowed_ff;
assign push_ovf = new_err && q_full_data && !overflowed_ff; // [RL8]
assign do_push = (new_err && !q_full_data) || push_ovf; // [RL23]
assign push_code = push_ovf ? `IESL_ERR_OVERFLOW : new_code;

always @(posedge clk)
begin
  if (do_push)
    queue_mem[wr_ptr_ff] <= push_code;
end

always @(posedge clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    wr_ptr_ff <= 4'h0;
    rd_ptr_ff <= 4'h0;
    count_ff <= 5'h00;
    overflowed_ff <= 1'b0;
    err_code_ff <= `IESL_ERR_NONE;
    err_empty_ff <= 1'b1;
  end
  else
  begin
    if (do_push)
      wr_ptr_ff <= wr_ptr_ff + 4'h1;
    if (do_pop)
      rd_ptr_ff <= rd_ptr_ff + 4'h1;
    if (do_push && !do_pop)
      count_ff <= count_ff + 5'h01;
    else if (!do_push && do_pop)
      count_ff <= count_ff - 5'h01;
    if (push_ovf)
      overflowed_ff <= 1'b1;
    else if (do_pop && (count_ff == 5'h01))
      overflowed_ff <= 1'b0;
    if (err_read_p)
      err_code_ff <= do_pop ? queue_mem[rd_ptr_ff] : `IESL_ERR_NONE; // [RL23]
    err_empty_ff <= ((count_ff == 5'h00) || ((count_ff == 5'h01) && do_pop)) && !do_push;
  end
end

////////////////////////////////////////////////////////////////////////////////
// event status bits, set wins over clear
always @(posedge clk or negedge rst_n)
begin
  if (!rst_n)
    esr_ff <= 8'h00;
  else
  begin
    if (esr_clear_p || (device_clear_p && !clear_as_reset_ff)) // [RL13]
      esr_ff <= 8'h00;
    if (events[11:6] != 6'h00) // [RL24]
      esr_ff[`IESL_ESR_EXEC] <= 1'b1;
    if ((events[5:3] != 3'h0) || push_ovf || ov_uv_detect) // [RL11]
      esr_ff[`IESL_ESR_DEVICE] <= 1'b1;
    if (events[2:1] != 2'h0)
      esr_ff[`IESL_ESR_QUERY] <= 1'b1;
  end
end

////////////////////////////////////////////////////////////////////////////////
// stage response watchdog and output buffer occupancy
always @(posedge clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    stage_wait_ff <= 1'b0;
    stage_cnt_ff <= 13'h0000;
    outbuf_cnt_ff <= 8'h00;
    pending_query_ff <= 1'b0;
  end
  else
  begin
    if (stage_cmd_p)
    begin
      stage_wait_ff <= 1'b1;
      stage_cnt_ff <= 13'h0000;
    end
    else if (stage_ack_p || stage_timeout)
      stage_wait_ff <= 1'b0; // [RL5]
    else if (stage_wait_ff)
      stage_cnt_ff <= stage_cnt_ff + 13'h0001;
    if (host_read_p || device_clear_p)
      outbuf_cnt_ff <= 8'h00;
    else if (resp_byte_p && !query_lost)
      outbuf_cnt_ff <= outbuf_cnt_ff + 8'h01; // [RL9]
    if (query_sent_p)
      pending_query_ff <= 1'b1; // [RL10]
    else if (host_read_p || device_clear_p)
      pending_query_ff <= 1'b0;
  end
end

////////////////////////////////////////////////////////////////////////////////
// behaviour-select options and output state
wire do_reset;
assign do_reset = reset_cmd_p || (device_clear_p && clear_as_reset_ff); // [RL14]

always @(posedge clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    boot_ff <= 1'b1;
    clear_as_reset_ff <= 1'b0;
    filler_lf_ff <= 1'b0;
    reset_out_on_ff <= 1'b0;
    output_on_ff <= 1'b0;
    setpoint_zero_ff <= 1'b1;
    status_clear_ff <= 1'b0;
    save_opts_ff <= 3'h0;
    save_strobe_ff <= 1'b0;
    read_byte_ff <= 8'h00;
    read_valid_ff <= 1'b0;
    version_year_ff <= 16'h0000;
    version_rev_ff <= 4'h0;
  end
  else
  begin
    boot_ff <= 1'b0;
    version_year_ff <= `IESL_VERSION_YEAR; // [RL20]
    version_rev_ff <= `IESL_VERSION_REV;
    status_clear_ff <= device_clear_p && !clear_as_reset_ff; // [RL13]
    save_strobe_ff <= diag_save_p && password_enabled; // [RL22]
    save_opts_ff <= {clear_as_reset_ff, filler_lf_ff, reset_out_on_ff}; // [RL19]
    if (boot_ff)
    begin
      clear_as_reset_ff <= saved_opts[2];
      filler_lf_ff <= saved_opts[1];
      reset_out_on_ff <= saved_opts[0];
      output_on_ff <= 1'b0; // [RL16]
    end
    else if (factory_init_p)
    begin
      clear_as_reset_ff <= 1'b0; // [RL12]
      filler_lf_ff <= 1'b1;
      reset_out_on_ff <= 1'b0;
    end
    else if (preset_std_p || preset_legacy_p)
    begin
      clear_as_reset_ff <= preset_legacy_p; // [RL18]
      filler_lf_ff <= preset_legacy_p;
      reset_out_on_ff <= preset_legacy_p;
    end
    else
    begin
      if (set_status_only_p || set_clear_reset_p)
        clear_as_reset_ff <= set_clear_reset_p;
      if (set_no_filler_p || set_filler_p)
        filler_lf_ff <= set_filler_p;
      if (set_reset_off_p || set_reset_on_p)
        reset_out_on_ff <= set_reset_on_p;
    end
    if (!boot_ff)
    begin
      if (window_fault && output_on_ff)
        output_on_ff <= 1'b0; // [RL6]
      else if (do_reset)
        output_on_ff <= reset_out_on_ff; // [RL16] [RL17]
      else if (output_on_cmd_p)
        output_on_ff <= 1'b1; // [RL17]
      else if (output_off_cmd_p)
        output_on_ff <= 1'b0;
    end
    setpoint_zero_ff <= do_reset || boot_ff;
    read_valid_ff <= host_read_p && (outbuf_cnt_ff == 8'h00) && filler_lf_ff; // [RL15]
    read_byte_ff <= (host_read_p && (outbuf_cnt_ff == 8'h00) && filler_lf_ff) ?
      `IESL_LF_CHAR : 8'h00;
  end
end

endmodule

// ===== bench/iesl_core_chk.sv
// assertion checker for the error and setup core
module iesl_core_chk (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // observed commands and events
  input wire cal_cmd_p,
  input wire cal_enabled,
  input wire value_out_of_range_p,
  input wire err_read_p,
  input wire esr_clear_p,
  input wire preset_std_p,
  input wire preset_legacy_p,
  input wire factory_init_p,
  // observed results
  input wire [8:0] err_code_ff,
  input wire err_empty_ff,
  input wire [7:0] esr_ff,
  input wire clear_as_reset_ff,
  input wire filler_lf_ff,
  input wire reset_out_on_ff,
  input wire [15:0] version_year_ff,
  input wire [3:0] version_rev_ff
);
  timeunit 1ns;
  timeprecision 100ps;
  reg [2:0] up_cnt;
  wire [2:0] opts = {clear_as_reset_ff, filler_lf_ff, reset_out_on_ff};
  wire one_preset = $onehot({preset_std_p, preset_legacy_p, factory_init_p});
  // cycles since reset release, saturating
  always @(posedge clk or negedge arst_n)
    if (!arst_n)
      up_cnt <= 3'h0;
    else if (up_cnt != 3'h7)
      up_cnt <= up_cnt + 3'h1;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_conflict_exec_bit:
    assert property (cal_cmd_p && !cal_enabled && !esr_clear_p |=> esr_ff[4])
    else $error("conflict left exec bit clear");
  a_range_exec_bit:
    assert property (value_out_of_range_p && !esr_clear_p |=> esr_ff[4])
    else $error("range error left exec bit clear");
  a_first_code_out:
    assert property (err_empty_ff && value_out_of_range_p && !cal_cmd_p ##1 err_read_p
      |=> err_code_ff == 9'h122)
    else $error("range code not read back");
  a_empty_reads_zero:
    assert property (err_read_p && err_empty_ff |=> err_code_ff == 9'h000)
    else $error("empty queue gave nonzero code");
  a_std_preset:
    assert property (preset_std_p && one_preset |=> opts == 3'h0)
    else $error("standard preset options wrong");
  a_legacy_preset:
    assert property (preset_legacy_p && one_preset |=> opts == 3'h7)
    else $error("legacy preset options wrong");
  a_factory_init:
    assert property (factory_init_p && one_preset |=> opts == 3'h2)
    else $error("factory init options wrong");
  a_version_value:
    assert property (up_cnt == 3'h7 |-> version_year_ff == 16'h07cd && version_rev_ff == 4'h0)
    else $error("version value wrong");
endmodule
bind iesl_core iesl_core_chk i_chk (.*);

// ===== bench/iesl_host_mdl.sv
// host controller model: sends queries and reads replies
module iesl_host_mdl (
  // clock
  input wire clk,
  // requests from the test sequence
  input wire ask,
  input wire fetch,
  // bus events towards the device
  output logic query_sent_p,
  output logic host_read_p
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    query_sent_p = 1'b0;
    host_read_p = 1'b0;
  end
  always @(posedge clk)
  begin
    query_sent_p <= ask;
    host_read_p <= fetch;
  end
endmodule

// ===== bench/tb_top.sv
// self-checking bench for the error and setup core
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [25:0] ev = '0;
  logic ask = 1'b0;
  logic fetch = 1'b0;
  logic cal_enabled = 1'b0;
  logic volt_window_fault = 1'b0;
  logic curr_window_fault = 1'b0;
  logic ov_uv_detect = 1'b0;
  logic password_enabled = 1'b0;
  logic [1:0] output_check_mode = 2'h0;
  logic [7:0] dwell_count = 8'h01;
  logic [7:0] volt_count = 8'h03;
  logic [7:0] curr_count = 8'h03;
  logic [2:0] saved_opts = 3'h0;
  wire query_sent_p, host_read_p, err_empty_ff, output_on_ff, setpoint_zero_ff, status_clear_ff;
  wire clear_as_reset_ff, filler_lf_ff, reset_out_on_ff, read_valid_ff, save_strobe_ff;
  wire [8:0] err_code_ff;
  wire [7:0] esr_ff, read_byte_ff;
  wire [2:0] save_opts_ff;
  wire [15:0] version_year_ff;
  wire [3:0] version_rev_ff;
  int n_fail = 0;
  int total_checks = 0;
  logic [25:0] emask [6] = '{26'h200_0000, 26'h100_0000, 26'h080_0000, 26'h040_0000,
    26'h004_0000, 26'h002_0000};
  logic [8:0] ecode [6] = '{9'h123, 9'h123, 9'h122, 9'h121, 9'h0c9, 9'h119};
  int ebit [6] = '{4, 4, 4, 4, 3, 4};
  logic [25:0] omask [10] = '{26'h000_0040, 26'h000_0080, 26'h000_0020, 26'h000_0080,
    26'h000_1000, 26'h000_0400, 26'h000_0100, 26'h000_2000, 26'h000_0800, 26'h000_0200};
  logic [2:0] oexp [10] = '{3'h7, 3'h0, 3'h2, 3'h0, 3'h4, 3'h6, 3'h7, 3'h3, 3'h1, 3'h0};
  iesl_host_mdl i_host (.*);
  iesl_core i_dut (.*, .cal_cmd_p(ev[25]), .list_dir_down_p(ev[24]),
    .value_out_of_range_p(ev[23]), .list_full_p(ev[22]), .list_cmd_done_p(ev[21]),
    .stage_cmd_p(ev[20]), .stage_ack_p(ev[19]), .memory_fail_p(ev[18]),
    .protected_cmd_p(ev[17]), .resp_byte_p(ev[16]), .err_read_p(ev[15]),
    .esr_clear_p(ev[14]), .set_status_only_p(ev[13]), .set_clear_reset_p(ev[12]),
    .set_no_filler_p(ev[11]), .set_filler_p(ev[10]), .set_reset_off_p(ev[9]),
    .set_reset_on_p(ev[8]), .preset_std_p(ev[7]),
    .preset_legacy_p(ev[6]), .factory_init_p(ev[5]), .diag_save_p(ev[4]),
    .reset_cmd_p(ev[3]), .device_clear_p(ev[2]), .output_on_cmd_p(ev[1]),
    .output_off_cmd_p(ev[0]));
  initial forever #12.5 clk = ~clk;
  initial
  begin
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
  end
  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic pulse(input logic [25:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= '0;
    #1;
  endtask
  task automatic hreq(input logic a, input logic f);
    @(posedge clk);
    ask <= a;
    fetch <= f;
    @(posedge clk);
    ask <= 1'b0;
    fetch <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  // status bit set, one code read back, status cleared
  task automatic chk_err(input logic [8:0] c, input int b);
    cmp("esr bit", 16'h1, esr_ff[b]);
    pulse(26'h000_8000);
    cmp("err code", c, err_code_ff);
    pulse(26'h000_4000);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    #500000;
    n_fail++;
    $display("[ERR] watchdog expected finish seen timeout");
    end_of_test();
  end
  initial
  begin
    @(posedge arst_n);
    repeat (6) @(posedge clk);
    // error and error query on consecutive cycles
    @(posedge clk) ev <= 26'h080_0000;
    @(posedge clk) ev <= 26'h000_8000;
    @(posedge clk) ev <= '0;
    #1;
    cmp("back to back code", 16'h0122, err_code_ff);
    cmp("empty after read", 16'h1, err_empty_ff);
    pulse(26'h000_4000);
    for (int i = 0; i < 6; i++)
    begin
      pulse(emask[i]);
      chk_err(ecode[i], ebit[i]);
    end
    @(posedge clk) cal_enabled <= 1'b1;
    pulse(26'h200_0000);
    cmp("cal enabled", 16'h0, esr_ff[4]);
    pulse(26'h020_0000);
    pulse(26'h000_8000);
    cmp("dwell one", 16'h0, err_code_ff);
    @(posedge clk) dwell_count <= 8'h02;
    pulse(26'h020_0000);
    chk_err(9'h11e, 4);
    pulse(26'h010_0000);
    pulse(26'h008_0000);
    repeat (4005) @(posedge clk);
    #1;
    cmp("stage answered", 16'h0, esr_ff[4]);
    pulse(26'h010_0000);
    repeat (4005) @(posedge clk);
    #1;
    chk_err(9'h110, 4);
    $display("test error sources done");
    @(posedge clk) ev <= 26'h001_0000;
    repeat (253) @(posedge clk);
    ev <= '0;
    @(posedge clk);
    #1;
    cmp("253 chars", 16'h0, esr_ff[2]);
    pulse(26'h001_0000);
    chk_err(9'h070, 2);
    hreq(1'b0, 1'b1);
    hreq(1'b1, 1'b0);
    pulse(26'h001_0000);
    hreq(1'b1, 1'b0);
    chk_err(9'h05c, 2);
    hreq(1'b0, 1'b1);
    for (int j = 0; j < 2; j++)
    begin
      pulse(26'h000_0002);
      @(posedge clk)
      begin
        output_check_mode <= j ? 2'h3 : 2'h1;
        {curr_window_fault, volt_window_fault} <= j ? 2'h2 : 2'h1;
      end
      repeat (2) @(posedge clk);
      #1;
      cmp("window off", 16'h0, output_on_ff);
      @(posedge clk) {curr_window_fault, volt_window_fault} <= 2'h0;
      chk_err(j ? 9'h0d2 : 9'h0d3, 3);
    end
    @(posedge clk) ov_uv_detect <= 1'b1;
    @(posedge clk) ov_uv_detect <= 1'b0;
    #1;
    cmp("ov uv bit", 16'h1, esr_ff[3]);
    pulse(26'h000_4000);
    repeat (17) pulse(26'h080_0000);
    cmp("device bit", 16'h1, esr_ff[3]);
    cmp("queue not empty", 16'h0, err_empty_ff);
    for (int k = 0; k < 17; k++)
    begin
      pulse(26'h000_8000);
      cmp("queue", k < 15 ? 16'h0122 : k < 16 ? 16'h00a2 : 16'h0, err_code_ff);
    end
    cmp("queue empty", 16'h1, err_empty_ff);
    $display("test queue done");
    for (int i = 0; i < 10; i++)
    begin
      pulse(omask[i]);
      cmp("options", oexp[i], {clear_as_reset_ff, filler_lf_ff, reset_out_on_ff});
    end
    pulse(26'h000_0020);
    hreq(1'b0, 1'b1);
    cmp("filler", 16'h010a, {read_valid_ff, read_byte_ff});
    pulse(26'h000_0800);
    hreq(1'b0, 1'b1);
    cmp("no filler", 16'h0, read_valid_ff);
    pulse(26'h000_0040);
    pulse(26'h000_0008);
    cmp("reset on", 16'h3, {output_on_ff, setpoint_zero_ff});
    pulse(26'h000_0080);
    pulse(26'h000_0008);
    cmp("reset off", 16'h1, {output_on_ff, setpoint_zero_ff});
    pulse(26'h000_0002);
    pulse(26'h000_0004);
    cmp("clear status only", 16'h3, {output_on_ff, status_clear_ff});
    pulse(26'h000_0040);
    pulse(26'h000_0200);
    pulse(26'h000_0004);
    cmp("clear as reset", 16'h1, {output_on_ff, setpoint_zero_ff});
    pulse(26'h000_0010);
    cmp("save locked", 16'h0, save_strobe_ff);
    @(posedge clk) password_enabled <= 1'b1;
    pulse(26'h000_0010);
    cmp("save", 16'h000e, {save_strobe_ff, save_opts_ff});
    pulse(26'h002_0000);
    cmp("unlocked command", 16'h0, esr_ff[4]);
    cmp("version", 16'h07cd, version_year_ff);
    cmp("revision", 16'h0, version_rev_ff);
    $display("test options done");
    end_of_test();
  end
endmodule
